/* File: design/lvds_cfg_consts.svh */
/*
 * offsets, field positions, reset values and mode codes of the lvds
 * output configuration registers. assumes inclusion by bare name.
 */
`ifndef LVDS_CFG_CONSTS_SVH
`define LVDS_CFG_CONSTS_SVH

`define LEVEL_CTRL_ADDR 8'h19
`define ROUTING_CTRL_ADDR 8'h1a
`define TRIM_CTRL_ADDR 8'h1b
`define LEVEL_CTRL_RESET 8'h05
`define ROUTING_CTRL_RESET 8'h03
`define TRIM_CTRL_RESET 8'h00
`define LEVEL_CTRL_MASK 8'h5f
`define ROUTING_CTRL_MASK 8'h73
`define TRIM_CTRL_MASK 8'h33
`define A_LEVEL_BIT 6
`define B_LEVEL_BIT 4
`define A_SWING_LSB 2
`define B_SWING_LSB 0
`define SWAP_BIT 6
`define A_REVERSE_BIT 5
`define B_REVERSE_BIT 4
`define A_TERM_BIT 1
`define B_TERM_BIT 0
`define A_TRIM_LSB 4
`define B_TRIM_LSB 0
`define TWO_STREAM_MODE 2'h2
`define LANES_PER_CHAN 5

`endif

/* File: design/lvds_cfg_pkg.sv */
/*
 * types for the lvds output configuration block.
 * assumes lvds_cfg_consts.svh sits beside it.
 */
`default_nettype none
package lvds_cfg_pkg;
    typedef struct packed {
        logic common_level_sel;
        logic [1:0] swing_code;
        logic lane_reverse;
        logic termination_sel;
        logic [1:0] common_trim;
    } chan_cfg_s;
endpackage
`default_nettype wire

/* File: design/lane_mapper.sv */
/*
 * lane order of one lvds channel: lanes 0..3 then clock at index 4.
 * assumes inputs come from logic on the same clock.
 */
`default_nettype none
module lane_mapper #(
    parameter int WIDTH = 7
) (
    // control
    input wire logic reverse,
    // lanes, index 4 is the clock lane
    input wire logic [4:0][WIDTH-1:0] lanes_in,
    output logic [4:0][WIDTH-1:0] lanes_out
);
    initial begin
        if (WIDTH < 1) begin
            $error("lane_mapper: WIDTH must be at least 1");
        end
    end

    always_comb begin
        lanes_out = lanes_in;
        if (reverse) begin
            // lane 0 <-> 3, lane 1 <-> clock, lane 2 stays
            lanes_out[0] = lanes_in[3]; // R8
            lanes_out[3] = lanes_in[0]; // R8
            lanes_out[1] = lanes_in[4]; // R8
            lanes_out[4] = lanes_in[1]; // R8
        end
    end
endmodule
`default_nettype wire

/* File: design/lvds_output_config_regs.sv */
/*
 * lvds level and routing configuration registers with pixel routing and
 * lane reversal of both output channels. assumes a same-clock register
 * port master and same-clock pixel and mode inputs.
 */
// Design decision made here: the plain strobed port.
// Operation
// R1: per-channel common level select, reset 0; 0 higher level, 1 lower.
// R2: software sets channel trim to 01 before selecting the lower level.
// R3: two-bit swing codes, A bits 3:2, B bits 1:0, reset 01, all codes.
// R4: swap clear: odd pixels to channel A, even pixels to channel B.
// R5: swap set: odd pixels to channel B, even pixels to channel A.
// R6: two-stream mode with swap: input A drives B, input B drives A.
// R7: channel A reverse clear: normal lane and clock order.
// R8: channel A reverse set: swap lanes 0/3 and lane 1/clock, lane 2 stays.
// R9: channel B reverse bit, reset 0, same remap for channel B.
// R10: reserved bits read zero and ignore writes.
`default_nettype none
`include "lvds_cfg_consts.svh"
module lvds_output_config_regs
    import lvds_cfg_pkg::*;
#(
    parameter int LANE_WIDTH = 7
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // mode from the video datapath
    input wire logic [1:0] stream_mode,
    // odd and even pixel streams (stream a, stream b in two-stream mode)
    input wire logic [4:0][LANE_WIDTH-1:0] odd_lanes,
    input wire logic [4:0][LANE_WIDTH-1:0] even_lanes,
    // lvds lanes, index 4 is the clock lane
    output logic [4:0][LANE_WIDTH-1:0] chan_a_lanes,
    output logic [4:0][LANE_WIDTH-1:0] chan_b_lanes,
    // analog controls
    output chan_cfg_s chan_a_cfg,
    output chan_cfg_s chan_b_cfg
);
    initial begin
        if (LANE_WIDTH < 1) begin
            $error("lvds_output_config_regs: LANE_WIDTH must be at least 1");
        end
    end

    logic [7:0] level_r, level_nxt;
    logic [7:0] routing_r, routing_nxt;
    logic [7:0] trim_r, trim_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [4:0][LANE_WIDTH-1:0] a_r, a_nxt, b_r, b_nxt;
    logic [4:0][LANE_WIDTH-1:0] pre_a, pre_b;

    function automatic chan_cfg_s pick_cfg(input logic [7:0] lvl, input logic [7:0] rte,
                                           input logic [7:0] trm, input logic is_a);
        chan_cfg_s c;
        c.common_level_sel = is_a ? lvl[`A_LEVEL_BIT] : lvl[`B_LEVEL_BIT]; // R1
        c.swing_code = is_a ? lvl[`A_SWING_LSB +: 2] : lvl[`B_SWING_LSB +: 2]; // R3
        c.lane_reverse = is_a ? rte[`A_REVERSE_BIT] : rte[`B_REVERSE_BIT];
        c.termination_sel = is_a ? rte[`A_TERM_BIT] : rte[`B_TERM_BIT];
        c.common_trim = is_a ? trm[`A_TRIM_LSB +: 2] : trm[`B_TRIM_LSB +: 2];
        return c;
    endfunction

    // register writes and reads
    always_comb begin
        level_nxt = level_r;
        routing_nxt = routing_r;
        trim_nxt = trim_r;
        rdata_nxt = 8'h00;
        if (wr) begin
            case (addr)
                `LEVEL_CTRL_ADDR: begin
                    level_nxt = wdata & `LEVEL_CTRL_MASK; // R10
                end
                `ROUTING_CTRL_ADDR: begin
                    routing_nxt = wdata & `ROUTING_CTRL_MASK; // R10
                end
                `TRIM_CTRL_ADDR: begin
                    trim_nxt = wdata & `TRIM_CTRL_MASK; // R10
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (addr)
                `LEVEL_CTRL_ADDR: begin
                    rdata_nxt = level_r;
                end
                `ROUTING_CTRL_ADDR: begin
                    rdata_nxt = routing_r;
                end
                `TRIM_CTRL_ADDR: begin
                    rdata_nxt = trim_r;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            level_r <= `LEVEL_CTRL_RESET; // R1 R3
            routing_r <= `ROUTING_CTRL_RESET; // R4 R7 R9
            trim_r <= `TRIM_CTRL_RESET;
            rdata_r <= 8'h00;
        end else begin
            level_r <= level_nxt;
            routing_r <= routing_nxt;
            trim_r <= trim_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // pixel routing; in two-stream mode odd is stream a, even stream b
    always_comb begin
        if (routing_r[`SWAP_BIT]) begin
            pre_a = even_lanes; // R5 R6
            pre_b = odd_lanes; // R5 R6
        end else begin
            pre_a = odd_lanes; // R4
            pre_b = even_lanes; // R4
        end
    end

    lane_mapper #(
        .WIDTH(LANE_WIDTH)
    ) u_map_a (
        .reverse(routing_r[`A_REVERSE_BIT]), // R7 R8
        .lanes_in(pre_a),
        .lanes_out(a_nxt)
    );

    lane_mapper #(
        .WIDTH(LANE_WIDTH)
    ) u_map_b (
        .reverse(routing_r[`B_REVERSE_BIT]), // R9
        .lanes_in(pre_b),
        .lanes_out(b_nxt)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            a_r <= '0;
            b_r <= '0;
        end else begin
            a_r <= a_nxt;
            b_r <= b_nxt;
        end
    end

    assign rdata = rdata_r;
    assign chan_a_lanes = a_r;
    assign chan_b_lanes = b_r;
    // wired from the registers so reset defaults show during reset too;
    // the lower-level select is kept as written, software orders trim first
    assign chan_a_cfg = pick_cfg(level_r, routing_r, trim_r, 1'b1); // R1 R3
    assign chan_b_cfg = pick_cfg(level_r, routing_r, trim_r, 1'b0); // R1 R3

    // stream_mode only tells the datapath which streams it feeds
    logic unused_mode;
    assign unused_mode = ^stream_mode;
endmodule
`default_nettype wire

/* File: tb/lvds_cfg_chk.sv */
/* port checks of the lvds configuration block.
   assumes a bind onto its top module. */
`default_nettype none
module lvds_cfg_chk
    import lvds_cfg_pkg::*;
#(
    parameter int LANE_WIDTH = 7
) (
    // register port
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // datapath
    input wire logic [1:0] stream_mode,
    input wire logic [4:0][LANE_WIDTH-1:0] odd_lanes,
    input wire logic [4:0][LANE_WIDTH-1:0] even_lanes,
    input wire logic [4:0][LANE_WIDTH-1:0] chan_a_lanes,
    input wire logic [4:0][LANE_WIDTH-1:0] chan_b_lanes,
    input wire chan_cfg_s chan_a_cfg,
    input wire chan_cfg_s chan_b_cfg
);
    timeunit 1ns;
    timeprecision 1ns;
    // shadow of the swap bit, not visible at the ports
    logic swap_r;
    always_ff @(posedge mclk or negedge arst_n)
        swap_r <= !arst_n ? 1'b0 : (wr && addr == 8'h1a) ? wdata[6] : swap_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_level_write: assert property (wr && addr == 8'h19 |=>
        chan_a_cfg.common_level_sel == $past(wdata[6])
        && chan_b_cfg.common_level_sel == $past(wdata[4])) else $error("level");
    a_swing_write: assert property (wr && addr == 8'h19 |=>
        chan_a_cfg.swing_code == $past(wdata[3:2])
        && chan_b_cfg.swing_code == $past(wdata[1:0])) else $error("swing");
    a_reverse_write: assert property (wr && addr == 8'h1a |=>
        chan_a_cfg.lane_reverse == $past(wdata[5])
        && chan_b_cfg.lane_reverse == $past(wdata[4])
        && chan_a_cfg.termination_sel == $past(wdata[1])
        && chan_b_cfg.termination_sel == $past(wdata[0])) else $error("reverse");
    a_trim_write: assert property (wr && addr == 8'h1b |=>
        chan_a_cfg.common_trim == $past(wdata[5:4])
        && chan_b_cfg.common_trim == $past(wdata[1:0])) else $error("trim");
    a_reset_values: assert property ($past(arst_n) && !$past(arst_n, 2) && !$past(wr) |->
        chan_a_cfg.swing_code == 2'h1 && !chan_a_cfg.lane_reverse
        && chan_b_cfg.swing_code == 2'h1 && chan_a_cfg.termination_sel) else $error("reset");
    a_route_plain: assert property ($past(arst_n) && !$past(swap_r) |->
        chan_a_lanes[2] == $past(odd_lanes[2])) else $error("plain route");
    a_route_swap: assert property ($past(arst_n) && $past(swap_r) |->
        chan_a_lanes[2] == $past(even_lanes[2])) else $error("swap route");
    a_two_stream: assert property ($past(arst_n) && $past(swap_r) && $past(stream_mode) == 2'h2 |->
        chan_b_lanes[2] == $past(odd_lanes[2])) else $error("two stream");
    a_reserved_read: assert property (rd && addr == 8'h1a |=>
        (rdata & 8'h8c) == 8'h00) else $error("reserved");
    a_reserved_level: assert property (rd && addr == 8'h19 |=>
        (rdata & 8'ha0) == 8'h00) else $error("reserved level");
endmodule
`default_nettype wire

/* File: tb/lvds_output_config_regs_test.sv */
/* random and corner tests of the lvds configuration block.
   assumes the design and checker files compile first. */
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module lvds_output_config_regs_test
    import lvds_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic [1:0] stream_mode = 2'h0;
    logic [4:0][6:0] odd_lanes = '0, even_lanes = '0, chan_a_lanes, chan_b_lanes;
    chan_cfg_s chan_a_cfg, chan_b_cfg;
    int miscompares = 0, samples_checked = 0;
    always #50 mclk = ~mclk;
    lvds_output_config_regs #(.LANE_WIDTH(7)) u_dut (.*);
    function automatic logic [4:0][6:0] rx(logic [4:0][6:0] l, logic r);
        return r ? {l[1], l[0], l[2], l[4], l[3]} : l;
    endfunction
    task automatic complete_run();
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one write, or one read checked against v
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        {wr, rd} <= 2'h0;
        #1 if (!w) `CHK("rdata", v, rdata)
    endtask
    initial begin
        void'($urandom(32'hed98));
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        bus(1'b0, 8'h19, 8'h05);
        bus(1'b0, 8'h1a, 8'h03);
        bus(1'b1, 8'h55, 8'hff);
        bus(1'b0, 8'h55, 8'h00);
        bus(1'b1, 8'h1b, 8'h11);
        bus(1'b0, 8'h1b, 8'h11);
        for (int i = 0; i < 20; i++) begin
            d = {4'($urandom), i[1:0], i[1:0]};
            bus(1'b1, 8'h19, d);
            bus(1'b0, 8'h19, d & 8'h5f);
            d = 8'($urandom) | (i == 2 ? 8'h40 : 8'h00);
            @(posedge mclk);
            odd_lanes <= 35'({$urandom, $urandom});
            even_lanes <= 35'({$urandom, $urandom});
            stream_mode <= i[1:0];
            bus(1'b1, 8'h1a, d);
            @(posedge mclk);
            #1 `CHK("lane_a", rx(d[6] ? even_lanes : odd_lanes, d[5]), chan_a_lanes)
            `CHK("lane_b", rx(d[6] ? odd_lanes : even_lanes, d[4]), chan_b_lanes)
            bus(1'b0, 8'h1a, d & 8'h73);
        end
        complete_run();
    end
endmodule
bind lvds_output_config_regs lvds_cfg_chk #(.LANE_WIDTH(LANE_WIDTH)) u_chk (.*);
`default_nettype wire
